//--- bench/ddrsr_ctrl_model.sv
// Behavioural memory controller driving the SRAM pins from free-running link clocks.
// Assumes the bench calls burst() back to back or with idle gaps; one call per transfer.
`timescale 1ns/1ns
`default_nettype none
module ddrsr_ctrl_model #(
    parameter int DW = 18,
    parameter int NB = 2,
    parameter int AW = 20
) (
    input wire logic singleClkMode,
    output logic kClk,
    output logic kClkN,
    output logic cClk,
    output logic cClkN,
    output logic xferLoadStrobeN,
    output logic rdWrSel,
    output logic [AW-3:0] addrHigh,
    output logic burstStartBit1,
    output logic burstStartBit0,
    output logic [NB-1:0] byteLaneWriteSelN,
    output logic [DW-1:0] dqIn
);
    // ==============================================================
    // Clocks
    logic cRaw;
    int seq = 0;
    initial begin
        kClk = 1'h0;
        cRaw = 1'h0;
        xferLoadStrobeN = 1'h1;
        rdWrSel = 1'h0;
        {addrHigh, burstStartBit1, burstStartBit0} = '0;
        byteLaneWriteSelN = '1;
        dqIn = '0;
        #1;
        forever #16 kClk = ~kClk;
    end
    // Output clocks lag by a quarter period so echo timing tells them apart from K
    always @(kClk) cRaw <= #8 kClk;
    assign kClkN = ~kClk;
    assign cClk = singleClkMode | cRaw;
    assign cClkN = singleClkMode | ~cRaw;

    // ==============================================================
    // Transfers
    task automatic beats(input logic [4*DW-1:0] d, input logic [4*NB-1:0] s);
        int id;
        id = ++seq;
        for (int i = 0; i < 4; i++) begin
            if (i[0]) @(posedge kClk); else @(posedge kClkN);
            #8;
            dqIn = d[i*DW +: DW];
            byteLaneWriteSelN = s[i*NB +: NB];
        end
        @(posedge kClkN);
        #8;
        // A following burst already owns the bus; releasing would clobber its first beat
        if (id == seq) begin
            dqIn = ~dqIn;
            byteLaneWriteSelN = ~byteLaneWriteSelN;
        end
    endtask : beats

    task automatic burst(input logic rw, input logic [AW-1:0] a,
                         input logic [4*DW-1:0] d, input logic [4*NB-1:0] s);
        @(posedge kClk);
        #8;
        xferLoadStrobeN = 1'h0;
        rdWrSel = rw;
        {addrHigh, burstStartBit1, burstStartBit0} = a;
        @(posedge kClk);
        #8;
        xferLoadStrobeN = 1'h1;
        rdWrSel = ~rw;
        {addrHigh, burstStartBit1, burstStartBit0} = ~a;
        if (!rw) fork beats(d, s); join_none
    endtask : burst
endmodule : ddrsr_ctrl_model
`default_nettype wire

//--- bench/tb_ddrsr_pins.sv
// Self-checking bench for the burst-of-four DDR SRAM pin interface, 18-bit build.
// Assumes the controller model makes the link clocks; reads are checked on echo clock edges.
`timescale 1ns/1ns
`default_nettype none
module tb_ddrsr_pins import ddrsr_pkg::*;;
    localparam int DW = NARROW_DW;
    localparam int NB = DW / LANE_W;
    localparam int AW = NARROW_AW;
    logic clk, nrst, ce, singleClkMode, kClk, kClkN, cClk, cClkN;
    logic xferLoadStrobeN, rdWrSel, burstStartBit1, burstStartBit0;
    logic [AW-3:0] addrHigh;
    logic [NB-1:0] byteLaneWriteSelN;
    logic [DW-1:0] dqIn, dqOut;
    logic dqOe, echoClk, echoClkN, wrOverflow, lastEcho, echoChk;
    logic [3:0] hist = '0;
    logic [DW-1:0] mem [int];
    logic [DW-1:0] expQ [$];
    logic [AW-3:0] grp [4];
    int n_errors = 0, cmp_count = 0, seed = 35030, cyc = 0;

    // ==============================================================
    // Design and far side
    ddrsr_pins #(.DW(DW)) ddrsr_pins_i (
        .clk(clk), .nrst(nrst), .ce(ce), .kClk(kClk), .kClkN(kClkN), .cClk(cClk),
        .cClkN(cClkN), .singleClkMode(singleClkMode), .xferLoadStrobeN(xferLoadStrobeN),
        .rdWrSel(rdWrSel), .addrHigh(addrHigh), .burstStartBit1(burstStartBit1),
        .burstStartBit0(burstStartBit0), .byteLaneWriteSelN(byteLaneWriteSelN),
        .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .echoClk(echoClk), .echoClkN(echoClkN),
        .wrOverflow(wrOverflow));
    ddrsr_ctrl_model #(.DW(DW), .NB(NB), .AW(AW)) ddrsr_ctrl_model_i (
        .singleClkMode(singleClkMode), .kClk(kClk), .kClkN(kClkN), .cClk(cClk),
        .cClkN(cClkN), .xferLoadStrobeN(xferLoadStrobeN), .rdWrSel(rdWrSel),
        .addrHigh(addrHigh), .burstStartBit1(burstStartBit1),
        .burstStartBit0(burstStartBit0), .byteLaneWriteSelN(byteLaneWriteSelN), .dqIn(dqIn));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // ==============================================================
    // Checking
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check

    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // Echo edges mark each launched beat, since equal beats leave dqOut unchanged
    always @(posedge clk) begin
        #1;
        if (echoClk !== lastEcho && dqOe === 1'h1) begin
            if (expQ.size() == 0) check(1'h0, "unexpected read beat");
            else check(dqOut === expQ.pop_front(), "read data");
        end
        lastEcho = echoClk;
        hist = {hist[2:0], singleClkMode ? kClk : cClk};
        if (echoChk) check(echoClk === hist[2] || echoClk === hist[3], "echo clock");
        if (echoChk) check(echoClkN === ~echoClk, "echo clock pair");
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            $display("CHECK FAILED %0t timeout", $time);
            end_of_test();
        end
    end

    // ==============================================================
    // Transfers with a reference copy of the array
    task automatic wr(input int g, input logic [1:0] st, input logic [4*NB-1:0] s);
        logic [4*DW-1:0] d;
        d = (4*DW)'({$random(seed), $random(seed), $random(seed)});
        for (int i = 0; i < 4; i++)
            for (int b = 0; b < NB; b++)
                if (!s[i*NB+b])
                    mem[{grp[g], st + 2'(i)}][b*LANE_W +: LANE_W] = d[i*DW+b*LANE_W +: LANE_W];
        ddrsr_ctrl_model_i.burst(1'h0, {grp[g], st}, d, s);
    endtask : wr

    task automatic rd(input int g, input logic [1:0] st);
        for (int i = 0; i < 4; i++) expQ.push_back(mem[{grp[g], st + 2'(i)}]);
        ddrsr_ctrl_model_i.burst(1'h1, {grp[g], st}, '0, '1);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge kClk);
        @(posedge clk);
        #1;
    endtask : idle

    // ==============================================================
    // Main sequence
    initial begin
        nrst = 1'h0;
        ce = 1'h1;
        singleClkMode = 1'h0;
        echoChk = 1'h0;
        lastEcho = 1'h0;
        repeat (5) @(posedge clk);
        #1 nrst = 1'h1;
        repeat (20) @(posedge clk);
        #1 echoChk = 1'h1;
        for (int g = 0; g < 4; g++) grp[g] = (AW-2)'($random(seed));
        for (int g = 0; g < 4; g++) wr(g, 2'h0, '0);
        for (int k = 0; k < 8; k++) wr(k % 4, 2'($random(seed)), (4*NB)'($random(seed)));
        idle(4);
        for (int k = 0; k < 8; k++) rd(k % 4, 2'(k));
        for (int k = 0; k < 8; k++) begin
            wr(k % 2, 2'($random(seed)), (4*NB)'($random(seed)));
            rd(2 + k % 2, 2'(k));
        end
        idle(6);
        // Freeze and mode switch only while idle; echo check paused across the change
        echoChk = 1'h0;
        ce = 1'h0;
        repeat (3) @(posedge clk);
        #1 ce = 1'h1;
        singleClkMode = 1'h1;
        repeat (12) @(posedge clk);
        #1 echoChk = 1'h1;
        for (int k = 0; k < 4; k++) rd(k, 2'(k + 1));
        idle(8);
        check(expQ.size() == 0, "missing read beats");
        check(dqOe === 1'h0, "drivers not released");
        check(wrOverflow === 1'h0, "write beat lost");
        end_of_test();
    end
endmodule : tb_ddrsr_pins
`default_nettype wire

//--- core/ddrsr_fifo.sv
// Small FIFO with a registered output stage.
// Assumes both sides run on one clock; count and pointers share the clock enable.
`timescale 1ns/1ns
`default_nettype none
module ddrsr_fifo import ddrsr_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [PW:0] count_q, count_d;
    logic outValid_q, outValid_d;
    logic [WIDTH-1:0] outData_q;
    logic push, pop;

    // ==============================================================
    // Pointer and count
    always_comb begin
        push = inValid && (count_q != (PW+1)'(DEPTH));
        pop = (count_q != '0) && (!outValid_q || outReady);
        wrPtr_d = push ? wrPtr_q + PW'(1) : wrPtr_q;
        rdPtr_d = pop ? rdPtr_q + PW'(1) : rdPtr_q;
        count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
        outValid_d = pop ? 1'b1 : (outReady ? 1'b0 : outValid_q);
        inReady = (count_q != (PW+1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            outValid_q <= 1'b0;
            outData_q <= '0;
        end else if (ce) begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            outValid_q <= outValid_d;
            if (pop) begin
                outData_q <= mem[rdPtr_q];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    assign outValid = outValid_q;
    assign outData = outData_q;

endmodule : ddrsr_fifo
`default_nettype wire

//--- core/ddrsr_pins.sv
// Pin interface of a double-data-rate burst-of-four SRAM, with its storage array.
// Assumes every pin, link clocks included, is sampled by clk at 8 cycles per link period.
`timescale 1ns/1ns
`default_nettype none
module ddrsr_pins import ddrsr_pkg::*; #(
    parameter int DW = NARROW_DW,
    parameter int NB = DW / LANE_W,
    parameter int AW = (DW == NARROW_DW) ? NARROW_AW : WIDE_AW
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic kClk,
    input wire logic kClkN,
    input wire logic cClk,
    input wire logic cClkN,
    input wire logic singleClkMode,
    input wire logic xferLoadStrobeN,
    input wire logic rdWrSel,
    input wire logic [AW-3:0] addrHigh,
    input wire logic burstStartBit1,
    input wire logic burstStartBit0,
    input wire logic [NB-1:0] byteLaneWriteSelN,
    input wire logic [DW-1:0] dqIn,
    output logic [DW-1:0] dqOut,
    output logic dqOe,
    output logic echoClk,
    output logic echoClkN,
    output logic wrOverflow
);
    localparam int PW = 4 + 3 + AW + NB + DW;
    localparam int FW = AW + NB + DW;

    // ==============================================================
    // Reset release and pin synchronisers
    logic [SYNC_STAGES-1:0] rstSync_q;
    logic rstN;
    logic [PW-1:0] pinMeta_q, pinSync_q;
    logic [3:0] clkPrev_q;
    logic [PW-1:0] pinRaw;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstSync_q <= '0;
        end else begin
            rstSync_q <= {rstSync_q[SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rstN = rstSync_q[SYNC_STAGES-1];

    assign pinRaw = {kClk, kClkN, cClk, cClkN, singleClkMode, xferLoadStrobeN, rdWrSel,
        addrHigh, burstStartBit1, burstStartBit0, byteLaneWriteSelN, dqIn};

    // Clocks and data share the same two-stage delay, so edge and data stay aligned
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
            clkPrev_q <= '0;
        end else if (ce) begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
            clkPrev_q <= pinSync_q[PW-1 -: 4];
        end
    end

    logic [3:0] clkS;
    logic singleS, ldNS, rwS;
    logic [AW-1:0] addrS;
    logic [NB-1:0] bwsNS;
    logic [DW-1:0] dataS;
    logic kRise, knRise, outRise, outnRise;

    assign {clkS, singleS, ldNS, rwS, addrS, bwsNS, dataS} = pinSync_q;
    assign kRise = clkS[CK_K] && !clkPrev_q[CK_K];
    assign knRise = clkS[CK_KN] && !clkPrev_q[CK_KN];
    assign outRise = singleS ? kRise : (clkS[CK_C] && !clkPrev_q[CK_C]);
    assign outnRise = singleS ? knRise : (clkS[CK_CN] && !clkPrev_q[CK_CN]);

    // ==============================================================
    // Write burst capture
    logic wrNextValid_q, wrNextValid_d, wrActive_q, wrActive_d;
    logic [AW-1:0] wrNext_q, wrNext_d, wrBase_q, wrBase_d;
    logic [1:0] wrBeat_q, wrBeat_d, pushBeat;
    logic pushValid, fifoInReady, overflow_q, overflow_d;
    logic [AW-1:0] pushAddr;
    logic [NB-1:0] pushLanes;
    logic wrLoad, rdLoad;

    assign wrLoad = kRise && !ldNS && !rwS;
    assign rdLoad = kRise && !ldNS && rwS;

    always_comb begin
        wrNextValid_d = wrNextValid_q;
        wrNext_d = wrNext_q;
        wrActive_d = wrActive_q;
        wrBase_d = wrBase_q;
        wrBeat_d = wrBeat_q;
        pushValid = 1'b0;
        pushBeat = wrBeat_q;
        if (kRise) begin
            if (wrActive_q && wrBeat_q == BEAT_MID) begin
                pushValid = 1'b1;
                wrBeat_d = BEAT_LAST;
            end else if (wrNextValid_q) begin
                pushValid = 1'b1;
                pushBeat = BEAT_RST;
                wrBase_d = wrNext_q;
                wrActive_d = 1'b1;
                wrBeat_d = BEAT_FIRST_DONE;
                wrNextValid_d = 1'b0;
            end
        end else if (knRise && wrActive_q && wrBeat_q[0]) begin
            pushValid = 1'b1;
            wrBeat_d = wrBeat_q + 2'h1;
            wrActive_d = (wrBeat_q != BEAT_LAST);
        end
        // Load wins over the hand-over of the previous pending address
        if (wrLoad) begin
            wrNextValid_d = 1'b1;
            wrNext_d = addrS;
        end
        pushAddr = {(pushBeat == BEAT_RST && kRise && !(wrActive_q && wrBeat_q == BEAT_MID))
            ? wrNext_q[AW-1:2] : wrBase_q[AW-1:2], 2'h0};
        pushAddr[1:0] = ((pushBeat == BEAT_RST && kRise && !(wrActive_q && wrBeat_q == BEAT_MID))
            ? wrNext_q[1:0] : wrBase_q[1:0]) + pushBeat;
        pushLanes = ~bwsNS;
        // Beats cannot be held back on the pins; a full FIFO loses the beat and says so
        overflow_d = overflow_q || (pushValid && !fifoInReady);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrNextValid_q <= 1'b0;
            wrNext_q <= '0;
            wrActive_q <= 1'b0;
            wrBase_q <= '0;
            wrBeat_q <= BEAT_RST;
            overflow_q <= 1'b0;
        end else if (ce) begin
            wrNextValid_q <= wrNextValid_d;
            wrNext_q <= wrNext_d;
            wrActive_q <= wrActive_d;
            wrBase_q <= wrBase_d;
            wrBeat_q <= wrBeat_d;
            overflow_q <= overflow_d;
        end
    end

    // ==============================================================
    // Write buffer; reads take the array port first and stall draining
    logic fifoOutValid, fifoOutReady, rdLaunch, memWe;
    logic [FW-1:0] fifoOut;
    logic [AW-1:0] memWaddr;
    logic [NB-1:0] memWlanes;
    logic [DW-1:0] memWdata;

    assign fifoOutReady = !rdLaunch;
    assign memWe = fifoOutValid && fifoOutReady;
    assign {memWaddr, memWlanes, memWdata} = fifoOut;

    ddrsr_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) writeBuf (
        .clk(clk),
        .rstN(rstN),
        .ce(ce),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData({pushAddr, pushLanes, dataS}),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOut)
    );

    // ==============================================================
    // Read burst sequencing
    logic rdNextValid_q, rdNextValid_d, rdActive_q, rdActive_d, dqOe_q, dqOe_d;
    logic [AW-1:0] rdNext_q, rdNext_d, rdBase_q, rdBase_d, rdAddr;
    logic [1:0] rdBeat_q, rdBeat_d;
    logic rdTake;

    always_comb begin
        rdNextValid_d = rdNextValid_q;
        rdNext_d = rdNext_q;
        rdActive_d = rdActive_q;
        rdBase_d = rdBase_q;
        rdBeat_d = rdBeat_q;
        // Even beats on the complement rise, odd beats on the true rise
        rdLaunch = rdActive_q && ((outnRise && !rdBeat_q[0]) || (outRise && rdBeat_q[0]));
        rdAddr = {rdBase_q[AW-1:2], rdBase_q[1:0] + rdBeat_q};
        if (rdLaunch) begin
            rdBeat_d = rdBeat_q + 2'h1;
            rdActive_d = (rdBeat_q != BEAT_LAST);
        end
        rdTake = outRise && rdNextValid_q && (!rdActive_q || (rdLaunch && rdBeat_q == BEAT_LAST));
        if (rdTake) begin
            rdActive_d = 1'b1;
            rdBase_d = rdNext_q;
            rdBeat_d = BEAT_RST;
            rdNextValid_d = 1'b0;
        end
        if (rdLoad) begin
            rdNextValid_d = 1'b1;
            rdNext_d = addrS;
        end
        dqOe_d = rdLaunch ? 1'b1 : ((outRise || outnRise) ? 1'b0 : dqOe_q);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdNextValid_q <= 1'b0;
            rdNext_q <= '0;
            rdActive_q <= 1'b0;
            rdBase_q <= '0;
            rdBeat_q <= BEAT_RST;
            dqOe_q <= 1'b0;
        end else if (ce) begin
            rdNextValid_q <= rdNextValid_d;
            rdNext_q <= rdNext_d;
            rdActive_q <= rdActive_d;
            rdBase_q <= rdBase_d;
            rdBeat_q <= rdBeat_d;
            dqOe_q <= dqOe_d;
        end
    end

    // ==============================================================
    // Storage array, one memory per byte lane so each lane writes alone
    for (genvar i = 0; i < NB; i++) begin : gLane
        logic [LANE_W-1:0] laneMem [0:(2**AW)-1];
        logic [LANE_W-1:0] laneOut_q;
        always_ff @(posedge clk) begin
            if (ce && memWe && memWlanes[i]) begin
                laneMem[memWaddr] <= memWdata[i*LANE_W +: LANE_W];
            end
        end
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                laneOut_q <= '0;
            end else if (ce && rdLaunch) begin
                laneOut_q <= laneMem[rdAddr];
            end
        end
        assign dqOut[i*LANE_W +: LANE_W] = laneOut_q;
    end

    // ==============================================================
    // Echo clocks, free running from the selected output clock pair
    logic echoClk_q, echoClkN_q, echoClk_d, echoClkN_d;

    always_comb begin
        echoClk_d = singleS ? clkS[CK_K] : clkS[CK_C];
        echoClkN_d = singleS ? clkS[CK_KN] : clkS[CK_CN];
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            echoClk_q <= 1'b0;
            echoClkN_q <= 1'b0;
        end else if (ce) begin
            echoClk_q <= echoClk_d;
            echoClkN_q <= echoClkN_d;
        end
    end

    assign dqOe = dqOe_q;
    assign echoClk = echoClk_q;
    assign echoClkN = echoClkN_q;
    assign wrOverflow = overflow_q;

    // ==============================================================
    // Checks
    rd_load_cause_a: assert property (@(posedge clk) disable iff (!rstN)
        $rose(rdNextValid_q) |-> $past(kRise && !ldNS && rwS && ce))
        else $error("read load without true clock rise and read select");

    wr_load_dir_a: assert property (@(posedge clk) disable iff (!rstN)
        ce && kRise && !ldNS && !rwS |=> wrNextValid_q && wrNext_q == $past(addrS))
        else $error("write load not recorded");

    wdata_edge_a: assert property (@(posedge clk) disable iff (!rstN)
        pushValid |-> (kRise || knRise))
        else $error("write beat taken off an input clock rise");

    lane_mask_a: assert property (@(posedge clk) disable iff (!rstN)
        ce && pushValid && fifoInReady |=>
            writeBuf.mem[$past(writeBuf.wrPtr_q)][DW +: NB] == ~$past(bwsNS))
        else $error("lane enables not stored with the data beat");

    burst_wrap_a: assert property (@(posedge clk) disable iff (!rstN)
        ce && rdLaunch && rdBeat_q == BEAT_LAST |-> rdAddr[1:0] == rdBase_q[1:0] - 2'h1)
        else $error("burst counter not linear");

    oe_cause_a: assert property (@(posedge clk) disable iff (!rstN)
        $rose(dqOe_q) |-> $past(rdLaunch))
        else $error("data drivers on without a read beat");

    launch_edge_a: assert property (@(posedge clk) disable iff (!rstN)
        !$stable(dqOut) |-> $past(outRise || outnRise))
        else $error("read data changed off an output clock rise");

    single_launch_a: assert property (@(posedge clk) disable iff (!rstN)
        rdLaunch && singleS |-> (kRise || knRise))
        else $error("single clock mode launch off input clock");

    echo_follow_a: assert property (@(posedge clk) disable iff (!rstN)
        ce && !singleS |=> echoClk_q == $past(clkS[CK_C]) && echoClkN_q == $past(clkS[CK_CN]))
        else $error("echo clocks not following output clocks");

endmodule : ddrsr_pins
`default_nettype wire

//--- core/ddrsr_pkg.sv
// Shared constants for the burst-of-four DDR SRAM pin interface.
// Assumes the pins are sampled by a fast core clock, 8 cycles per link clock period.
package ddrsr_pkg;

    // ==============================================================
    // Geometry
    localparam int LANE_W = 9;
    localparam int BURST_LEN = 4;
    localparam int NARROW_DW = 18;
    localparam int NARROW_AW = 20;
    localparam int WIDE_AW = 19;
    localparam int FIFO_DEPTH = 8;

    // ==============================================================
    // Beat counter values; BEAT_RST is the value after reset
    localparam logic [1:0] BEAT_RST = 2'h0;
    localparam logic [1:0] BEAT_LAST = 2'h3;
    localparam logic [1:0] BEAT_MID = 2'h2;
    localparam logic [1:0] BEAT_FIRST_DONE = 2'h1;

    // ==============================================================
    // Synchroniser depth of the reset release; pin inputs use a fixed two stages
    localparam int SYNC_STAGES = 2;

    // Clock bit positions in the synchronised clock vector
    localparam int CK_K = 3;
    localparam int CK_KN = 2;
    localparam int CK_C = 1;
    localparam int CK_CN = 0;

endpackage : ddrsr_pkg
